// ### hdl/pmbpc_cfg.svh
/*
 * Constants for the power-control command bank: command codes, field
 * positions, reset values, linear-format exponents and setpoint ranges.
 * Assumes it is included by bare name from design and bench files.
 */
`ifndef PMBPC_CFG_SVH
`define PMBPC_CFG_SVH

// Command codes seen on the command port
`define PMBPC_CMD_MAIN_CONTROL 8'h01
`define PMBPC_CMD_ONOFF_CONFIG 8'h02
`define PMBPC_CMD_STORE_ALL 8'h11
`define PMBPC_CMD_VOUT_MODE 8'h20
`define PMBPC_CMD_SETPOINT 8'h21
`define PMBPC_CMD_MARGIN_HIGH 8'h25
`define PMBPC_CMD_MARGIN_LOW 8'h26
`define PMBPC_CMD_VIN_TURN_ON 8'h35
`define PMBPC_CMD_VIN_TURN_OFF 8'h36
`define PMBPC_CMD_START_DELAY 8'h60
`define PMBPC_CMD_START_RISE 8'h61
`define PMBPC_CMD_READ_VIN 8'h88
`define PMBPC_CMD_OUTPUT_VOLTAGE_READING 8'h8B
`define PMBPC_CMD_READ_IOUT 8'h8C
`define PMBPC_CMD_VOUT_CAL_OFS 8'hD0
`define PMBPC_CMD_VIN_CAL_OFS 8'hD1
`define PMBPC_CMD_VIN_CAL_GAIN 8'hD2
`define PMBPC_CMD_IOUT_CAL_OFS 8'hD3
`define PMBPC_CMD_IOUT_CAL_GAIN 8'hD4

// Main control byte fields and reset value
`define PMBPC_OP_ON_BIT 7
`define PMBPC_OP_WR_MASK 8'hB0
`define PMBPC_OP_RESET 8'h88
// Gating configuration fields and reset value
`define PMBPC_CFG_PU_BIT 4
`define PMBPC_CFG_CMD_BIT 3
`define PMBPC_CFG_CPR_BIT 2
`define PMBPC_CFG_POL_BIT 1
`define PMBPC_CFG_WR_MASK 8'h08
`define PMBPC_CFG_RESET 8'h1F

// Five-bit exponents of the linear words
`define PMBPC_EXP_VIN 5'h1D
`define PMBPC_EXP_TIME 5'h1F
`define PMBPC_EXP_IOUT 5'h1C
`define PMBPC_VOUT_MODE_WORD 16'h0014

// Legal mantissa ranges
`define PMBPC_VIN_MANT_MIN 11'h100
`define PMBPC_VIN_MANT_MAX 11'h170
`define PMBPC_TIME_MANT_MIN 11'h050
`define PMBPC_TIME_MANT_MAX 11'h3E8
`define PMBPC_VOUT_MANT_MIN 16'h5000
`define PMBPC_VOUT_MANT_MAX 16'hD333

// Reset values of the programmable words
`define PMBPC_VIN_ON_RESET 16'hE910
`define PMBPC_VIN_OFF_RESET 16'hE900
`define PMBPC_TIME_RESET 16'hF8A0
`define PMBPC_SETPOINT_RESET 16'hC000
`define PMBPC_MARGIN_HIGH_RESET 16'hC800
`define PMBPC_MARGIN_LOW_RESET 16'hB800

`endif

// ### hdl/pmbpc_pkg.sv
/*
 * Types shared by the power-control command bank.
 * Assumes nothing of its surroundings.
 */
package pmbpc_pkg;
    // Data word of every two-byte command
    typedef logic [15:0] pmbpc_word_t;
    // Margin state chosen by the main control byte
    typedef enum logic [1:0] {
        PMBPC_MARGIN_OFF,
        PMBPC_MARGIN_LOW,
        PMBPC_MARGIN_HIGH
    } pmbpc_margin_e;
endpackage

// ### hdl/pmbpc_sync.sv
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pmbpc_sync (
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Level in and out
    input wire logic i_async,
    output logic o_sync
);
    logic stage1;

    // First stage feeds only the second
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end else if (i_clk_en) begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule // pmbpc_sync
`default_nettype wire

// ### hdl/pmbpc_lin_cal.sv
/*
 * Gain and offset correction of an 11-bit linear telemetry mantissa.
 * Assumes raw value and offset share the output exponent; gain is in
 * units of one part in 8192.
 */
`timescale 1ns/1ps
`default_nettype none
module pmbpc_lin_cal (
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Raw sample and factory calibration
    input wire logic [10:0] i_raw,
    input wire logic [15:0] i_gain,
    input wire logic [10:0] i_offset,
    // Corrected, never-negative mantissa
    output logic [9:0] o_mant
);
    logic signed [27:0] product;
    logic signed [15:0] corrected;

    // Gain scaled down by 8192 keeps the raw exponent
    assign product = $signed(i_raw) * $signed({1'b0, i_gain});
    assign corrected = 16'(product >>> 13) + 16'($signed(i_offset));

    // Negative results read as zero, sinking current included
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_mant <= 10'h000;
        end else if (i_clk_en) begin
            if (corrected < 0) begin
                o_mant <= 10'h000;
            end else if (corrected > 16'sh03FF) begin
                o_mant <= 10'h3FF;
            end else begin
                o_mant <= corrected[9:0];
            end
        end
    end
endmodule // pmbpc_lin_cal
`default_nettype wire

// ### hdl/pmbpc_bank.sv
/*
 * Power-control command bank behind the management port: on/off gating,
 * margin selection, programmable thresholds, start timing and setpoints,
 * and calibrated telemetry words.
 * Assumes a framer on the same clock that hands over whole decoded
 * commands, factory calibration words held steady from nonvolatile
 * storage, converter samples on the same clock, and an asynchronous
 * on/off pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmbpc_cfg.svh"

module pmbpc_bank (
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Command port from the framer
    input wire logic [7:0] i_cmd_code,
    input wire logic i_cmd_wr,
    input wire pmbpc_pkg::pmbpc_word_t i_cmd_wdata,
    input wire logic i_cmd_rd,
    output pmbpc_pkg::pmbpc_word_t o_cmd_rdata,
    output logic o_cmd_rvalid,
    output logic o_cmd_err,
    // Analog on/off pin
    input wire logic i_onoff_pin,
    // Converter samples
    input wire logic [15:0] i_vout_raw,
    input wire logic [10:0] i_vin_raw,
    input wire logic [10:0] i_iout_raw,
    // Factory calibration from nonvolatile storage
    input wire logic [15:0] i_output_voltage_cal_offset,
    input wire logic [10:0] i_input_voltage_cal_offset,
    input wire logic [15:0] i_input_voltage_cal_gain,
    input wire logic [10:0] i_output_current_cal_offset,
    input wire logic [15:0] i_output_current_cal_gain,
    // Power stage controls
    output logic o_output_enable,
    output pmbpc_pkg::pmbpc_margin_e o_margin_sel,
    output pmbpc_pkg::pmbpc_word_t o_vout_target,
    output pmbpc_pkg::pmbpc_word_t o_input_turn_on_threshold,
    output pmbpc_pkg::pmbpc_word_t o_input_turn_off_threshold,
    output pmbpc_pkg::pmbpc_word_t o_start_delay_time,
    output pmbpc_pkg::pmbpc_word_t o_start_rise_time,
    output pmbpc_pkg::pmbpc_word_t o_output_setpoint,
    output pmbpc_pkg::pmbpc_word_t o_margin_high_setpoint,
    output pmbpc_pkg::pmbpc_word_t o_margin_low_setpoint,
    // Nonvolatile store request
    output logic o_nvm_store
);
    import pmbpc_pkg::*;

    // Linear word check: fixed exponent, sign clear, mantissa in range
    function automatic logic lin_ok(input pmbpc_word_t word, input logic [4:0] expo,
                                    input logic [10:0] lo, input logic [10:0] hi);
        lin_ok = (word[15:11] == expo) && !word[10] && (word[10:0] >= lo) && (word[10:0] <= hi);
    endfunction

    // Unsigned setpoint range check
    function automatic logic vout_ok(input pmbpc_word_t word);
        vout_ok = (word >= `PMBPC_VOUT_MANT_MIN) && (word <= `PMBPC_VOUT_MANT_MAX);
    endfunction

    logic [7:0] main_control_byte;
    logic [7:0] onoff_gating_config;
    logic pin_level;
    logic pin_asserted;
    logic pin_ok;
    logic cmd_ok;
    logic next_enable;
    pmbpc_margin_e next_margin;
    logic [9:0] vin_mant;
    logic [9:0] iout_mant;
    logic signed [16:0] vout_sum;
    pmbpc_word_t output_voltage_reading;
    pmbpc_word_t input_voltage_reading;
    pmbpc_word_t output_current_reading;
    pmbpc_word_t next_rdata;
    logic next_rd_err;
    logic wr_main;
    logic wr_cfg;
    logic wr_vin_on;
    logic wr_vin_off;
    logic wr_delay;
    logic wr_rise;
    logic wr_setpoint;
    logic wr_mhigh;
    logic wr_mlow;
    logic wr_store;
    logic wr_known;
    logic wr_bad;

    // Pin is asynchronous to this clock
    pmbpc_sync u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_async(i_onoff_pin),
        .o_sync(pin_level)
    );

    // Input voltage correction, exponent -3
    pmbpc_lin_cal u_vin_cal (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_raw(i_vin_raw),
        .i_gain(i_input_voltage_cal_gain),
        .i_offset(i_input_voltage_cal_offset),
        .o_mant(vin_mant)
    );

    // Output current correction, exponent -4
    pmbpc_lin_cal u_iout_cal (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_raw(i_iout_raw),
        .i_gain(i_output_current_cal_gain),
        .i_offset(i_output_current_cal_offset),
        .o_mant(iout_mant)
    );

    // Write decode by command code
    always_comb begin
        wr_main = 1'b0;
        wr_cfg = 1'b0;
        wr_vin_on = 1'b0;
        wr_vin_off = 1'b0;
        wr_delay = 1'b0;
        wr_rise = 1'b0;
        wr_setpoint = 1'b0;
        wr_mhigh = 1'b0;
        wr_mlow = 1'b0;
        wr_store = 1'b0;
        wr_known = 1'b1;
        if (i_cmd_code == `PMBPC_CMD_MAIN_CONTROL) begin
            wr_main = i_cmd_wr;
        end else if (i_cmd_code == `PMBPC_CMD_ONOFF_CONFIG) begin
            wr_cfg = i_cmd_wr;
        end else if (i_cmd_code == `PMBPC_CMD_VIN_TURN_ON) begin
            wr_known = lin_ok(i_cmd_wdata, `PMBPC_EXP_VIN, `PMBPC_VIN_MANT_MIN, `PMBPC_VIN_MANT_MAX);
            wr_vin_on = i_cmd_wr && wr_known;
        end else if (i_cmd_code == `PMBPC_CMD_VIN_TURN_OFF) begin
            wr_known = lin_ok(i_cmd_wdata, `PMBPC_EXP_VIN, `PMBPC_VIN_MANT_MIN, `PMBPC_VIN_MANT_MAX);
            wr_vin_off = i_cmd_wr && wr_known;
        end else if (i_cmd_code == `PMBPC_CMD_START_DELAY) begin
            wr_known = lin_ok(i_cmd_wdata, `PMBPC_EXP_TIME, `PMBPC_TIME_MANT_MIN, `PMBPC_TIME_MANT_MAX);
            wr_delay = i_cmd_wr && wr_known;
        end else if (i_cmd_code == `PMBPC_CMD_START_RISE) begin
            wr_known = lin_ok(i_cmd_wdata, `PMBPC_EXP_TIME, `PMBPC_TIME_MANT_MIN, `PMBPC_TIME_MANT_MAX);
            wr_rise = i_cmd_wr && wr_known;
        end else if (i_cmd_code == `PMBPC_CMD_SETPOINT) begin
            wr_setpoint = i_cmd_wr && vout_ok(i_cmd_wdata);
            wr_known = vout_ok(i_cmd_wdata);
        end else if (i_cmd_code == `PMBPC_CMD_MARGIN_HIGH) begin
            wr_mhigh = i_cmd_wr;
        end else if (i_cmd_code == `PMBPC_CMD_MARGIN_LOW) begin
            wr_mlow = i_cmd_wr;
        end else if (i_cmd_code == `PMBPC_CMD_STORE_ALL) begin
            wr_store = i_cmd_wr;
        end else begin
            wr_known = 1'b0;
        end
    end

    // Read-only codes and bad data both refuse a write
    assign wr_bad = i_cmd_wr && !wr_known;

    // Main control byte, writable bits only
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            main_control_byte <= `PMBPC_OP_RESET;
        end else if (i_clk_en && wr_main) begin
            main_control_byte <= (i_cmd_wdata[7:0] & `PMBPC_OP_WR_MASK)
                               | (main_control_byte & ~`PMBPC_OP_WR_MASK);
        end
    end

    // Gating configuration, only the response bit moves
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            onoff_gating_config <= `PMBPC_CFG_RESET;
        end else if (i_clk_en && wr_cfg) begin
            onoff_gating_config <= (i_cmd_wdata[7:0] & `PMBPC_CFG_WR_MASK)
                                 | (onoff_gating_config & ~`PMBPC_CFG_WR_MASK);
        end
    end

    // Programmable words; out-of-range writes keep the old value, margin words take any value
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_input_turn_on_threshold <= `PMBPC_VIN_ON_RESET;
            o_input_turn_off_threshold <= `PMBPC_VIN_OFF_RESET;
            o_start_delay_time <= `PMBPC_TIME_RESET;
            o_start_rise_time <= `PMBPC_TIME_RESET;
            o_output_setpoint <= `PMBPC_SETPOINT_RESET;
            o_margin_high_setpoint <= `PMBPC_MARGIN_HIGH_RESET;
            o_margin_low_setpoint <= `PMBPC_MARGIN_LOW_RESET;
        end else if (i_clk_en) begin
            if (wr_vin_on) begin
                o_input_turn_on_threshold <= i_cmd_wdata;
            end
            if (wr_vin_off) begin
                o_input_turn_off_threshold <= i_cmd_wdata;
            end
            if (wr_delay) begin
                o_start_delay_time <= i_cmd_wdata;
            end
            if (wr_rise) begin
                o_start_rise_time <= i_cmd_wdata;
            end
            if (wr_setpoint) begin
                o_output_setpoint <= i_cmd_wdata;
            end
            if (wr_mhigh) begin
                o_margin_high_setpoint <= i_cmd_wdata;
            end
            if (wr_mlow) begin
                o_margin_low_setpoint <= i_cmd_wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_nvm_store <= 1'b0;
        end else if (i_clk_en) begin
            o_nvm_store <= wr_store;
        end
    end

    // Pin polarity decides which level counts as asserted
    assign pin_asserted = (pin_level == onoff_gating_config[`PMBPC_CFG_POL_BIT]);

    assign pin_ok = !onoff_gating_config[`PMBPC_CFG_CPR_BIT] || pin_asserted;

    assign cmd_ok = !onoff_gating_config[`PMBPC_CFG_CMD_BIT] || main_control_byte[`PMBPC_OP_ON_BIT];

    assign next_enable = onoff_gating_config[`PMBPC_CFG_PU_BIT] && pin_ok && cmd_ok;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_output_enable <= 1'b0;
        end else if (i_clk_en) begin
            o_output_enable <= next_enable;
        end
    end

    always_comb begin
        case (main_control_byte[5:2])
            4'h6: next_margin = PMBPC_MARGIN_LOW;
            4'hA: next_margin = PMBPC_MARGIN_HIGH;
            default: next_margin = PMBPC_MARGIN_OFF;
        endcase
    end

    // Margin state and the target that the loop regulates to
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_margin_sel <= PMBPC_MARGIN_OFF;
            o_vout_target <= `PMBPC_SETPOINT_RESET;
        end else if (i_clk_en) begin
            o_margin_sel <= next_margin;
            case (next_margin)
                PMBPC_MARGIN_LOW: o_vout_target <= o_margin_low_setpoint;
                PMBPC_MARGIN_HIGH: o_vout_target <= o_margin_high_setpoint;
                default: o_vout_target <= o_output_setpoint;
            endcase
        end
    end

    // offset added; negative sums read zero, and sums past FFFF wrap negative and read zero too
    assign vout_sum = $signed({1'b0, i_vout_raw}) + 17'($signed(i_output_voltage_cal_offset));

    // Telemetry words rebuilt every cycle from the corrected values
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            output_voltage_reading <= 16'h0000;
            input_voltage_reading <= 16'h0000;
            output_current_reading <= 16'h0000;
        end else if (i_clk_en) begin
            if (vout_sum < 0) begin
                output_voltage_reading <= 16'h0000;
            end else if (vout_sum[16]) begin
                output_voltage_reading <= 16'hFFFF;
            end else begin
                output_voltage_reading <= vout_sum[15:0];
            end
            input_voltage_reading <= {`PMBPC_EXP_VIN, 1'b0, vin_mant};
            output_current_reading <= {`PMBPC_EXP_IOUT, 1'b0, iout_mant};
        end
    end

    // Read decode; unknown codes answer zero with an error
    always_comb begin
        next_rdata = 16'h0000;
        next_rd_err = 1'b0;
        if (i_cmd_code == `PMBPC_CMD_MAIN_CONTROL) begin
            next_rdata = {8'h00, main_control_byte};
        end else if (i_cmd_code == `PMBPC_CMD_ONOFF_CONFIG) begin
            next_rdata = {8'h00, onoff_gating_config};
        end else if (i_cmd_code == `PMBPC_CMD_VOUT_MODE) begin
            next_rdata = `PMBPC_VOUT_MODE_WORD;
        end else if (i_cmd_code == `PMBPC_CMD_SETPOINT) begin
            next_rdata = o_output_setpoint;
        end else if (i_cmd_code == `PMBPC_CMD_MARGIN_HIGH) begin
            next_rdata = o_margin_high_setpoint;
        end else if (i_cmd_code == `PMBPC_CMD_MARGIN_LOW) begin
            next_rdata = o_margin_low_setpoint;
        end else if (i_cmd_code == `PMBPC_CMD_VIN_TURN_ON) begin
            next_rdata = o_input_turn_on_threshold;
        end else if (i_cmd_code == `PMBPC_CMD_VIN_TURN_OFF) begin
            next_rdata = o_input_turn_off_threshold;
        end else if (i_cmd_code == `PMBPC_CMD_START_DELAY) begin
            next_rdata = o_start_delay_time;
        end else if (i_cmd_code == `PMBPC_CMD_START_RISE) begin
            next_rdata = o_start_rise_time;
        end else if (i_cmd_code == `PMBPC_CMD_OUTPUT_VOLTAGE_READING) begin
            next_rdata = output_voltage_reading;
        end else if (i_cmd_code == `PMBPC_CMD_READ_VIN) begin
            next_rdata = input_voltage_reading;
        end else if (i_cmd_code == `PMBPC_CMD_READ_IOUT) begin
            next_rdata = output_current_reading;
        end else if (i_cmd_code == `PMBPC_CMD_VOUT_CAL_OFS) begin
            next_rdata = i_output_voltage_cal_offset;
        end else if (i_cmd_code == `PMBPC_CMD_VIN_CAL_OFS) begin
            next_rdata = {`PMBPC_EXP_VIN, i_input_voltage_cal_offset};
        end else if (i_cmd_code == `PMBPC_CMD_VIN_CAL_GAIN) begin
            next_rdata = i_input_voltage_cal_gain;
        end else if (i_cmd_code == `PMBPC_CMD_IOUT_CAL_OFS) begin
            next_rdata = {`PMBPC_EXP_IOUT, i_output_current_cal_offset};
        end else if (i_cmd_code == `PMBPC_CMD_IOUT_CAL_GAIN) begin
            next_rdata = i_output_current_cal_gain;
        end else begin
            next_rd_err = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_cmd_rdata <= 16'h0000;
            o_cmd_rvalid <= 1'b0;
        end else if (i_clk_en) begin
            o_cmd_rvalid <= i_cmd_rd;
            if (i_cmd_rd) begin
                o_cmd_rdata <= next_rdata;
            end
        end
    end

    // Error pulse for refused writes and unknown reads
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_cmd_err <= 1'b0;
        end else if (i_clk_en) begin
            o_cmd_err <= wr_bad || (i_cmd_rd && next_rd_err);
        end
    end
endmodule // pmbpc_bank
`default_nettype wire

// ### tb/pmbpc_bank_sva.sv
/* Port checker for the command bank.
   Assumes it is bound into pmbpc_bank and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "pmbpc_cfg.svh"
module pmbpc_bank_chk import pmbpc_pkg::*; (
    input wire logic i_sys_clk, input wire logic i_sys_rst, input wire logic i_clk_en,
    input wire logic [7:0] i_cmd_code, input wire logic i_cmd_wr, input wire logic i_cmd_rd,
    input wire pmbpc_pkg::pmbpc_word_t i_cmd_wdata, input wire pmbpc_pkg::pmbpc_word_t o_cmd_rdata,
    input wire logic o_cmd_rvalid, input wire logic o_cmd_err, input wire logic i_onoff_pin,
    input wire logic o_output_enable, input wire logic o_nvm_store,
    input wire pmbpc_pkg::pmbpc_margin_e o_margin_sel, input wire pmbpc_pkg::pmbpc_word_t o_vout_target,
    input wire pmbpc_pkg::pmbpc_word_t o_output_setpoint, input wire pmbpc_pkg::pmbpc_word_t o_margin_high_setpoint,
    input wire pmbpc_pkg::pmbpc_word_t o_margin_low_setpoint
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    logic cmd_bit;
    // Shadow of the response bit, so the off check skips ignored commands
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) cmd_bit <= 1'b1;
        else if (i_clk_en && i_cmd_wr && i_cmd_code == `PMBPC_CMD_ONOFF_CONFIG) cmd_bit <= i_cmd_wdata[3];
    end
    sequence s_rd(logic [7:0] c); i_clk_en && i_cmd_rd && i_cmd_code == c; endsequence
    sequence s_wr(logic [7:0] c); i_clk_en && i_cmd_wr && i_cmd_code == c; endsequence
    a_op_disables: assert property (s_wr(`PMBPC_CMD_MAIN_CONTROL) ##0 (!i_cmd_wdata[7] && cmd_bit)
        |-> ##[2:3] !o_output_enable) else $error("output stayed on");
    a_pin_required: assert property (!i_onoff_pin [*4] |-> !o_output_enable) else $error("on without pin");
    a_read_answer: assert property (i_clk_en && i_cmd_rd |=> o_cmd_rvalid) else $error("no read answer");
    a_rvalid_cause: assert property (o_cmd_rvalid |-> $past(i_cmd_rd)) else $error("stray read valid");
    a_vin_format: assert property (s_rd(`PMBPC_CMD_READ_VIN) |=> o_cmd_rdata[15:10] == 6'h3A) else $error("vin format");
    a_iout_format: assert property (s_rd(`PMBPC_CMD_READ_IOUT) |=> o_cmd_rdata[15:10] == 6'h38) else $error("iout format");
    a_mode_word: assert property (s_rd(`PMBPC_CMD_VOUT_MODE) |=> o_cmd_rdata == `PMBPC_VOUT_MODE_WORD) else $error("mode");
    a_ro_refused: assert property (s_wr(`PMBPC_CMD_OUTPUT_VOLTAGE_READING) |=> o_cmd_err) else $error("reading was writable");
    a_margin_high: assert property (s_wr(`PMBPC_CMD_MAIN_CONTROL) ##0 i_cmd_wdata[5:2] == 4'hA
        |-> ##[1:2] o_margin_sel == PMBPC_MARGIN_HIGH) else $error("margin high not selected");
    a_target_mux: assert property ($stable(o_margin_sel) && $stable(o_output_setpoint) && $stable(o_margin_high_setpoint)
        && $stable(o_margin_low_setpoint) |-> o_vout_target == (o_margin_sel == PMBPC_MARGIN_HIGH ? o_margin_high_setpoint
        : o_margin_sel == PMBPC_MARGIN_LOW ? o_margin_low_setpoint : o_output_setpoint)) else $error("target");
    a_store_pulse: assert property (o_nvm_store |-> $past(i_cmd_wr && i_cmd_code == `PMBPC_CMD_STORE_ALL)
        ##1 !o_nvm_store) else $error("store without command");
endmodule // pmbpc_bank_chk
bind pmbpc_bank pmbpc_bank_chk u_chk (.*);
`default_nettype wire

// ### tb/pmbpc_host.sv
/* Host model on the command port: one write or read per call.
   Assumes the bank answers on the taking edge itself. */
`timescale 1ns/1ps
`default_nettype none
module pmbpc_host (
    // Clock and answers
    input wire logic i_clk,
    input wire pmbpc_pkg::pmbpc_word_t i_rdata,
    input wire logic i_err,
    // Requests
    output logic [7:0] o_code = 8'h00,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output pmbpc_pkg::pmbpc_word_t o_wdata = 16'h0000
);
    import pmbpc_pkg::*;
    // Released lines flip, so a stale code is never mistaken for a held one
    task automatic wr_cmd(input logic [7:0] c, input pmbpc_word_t d, output logic e);
        @(posedge i_clk) #1 o_code = c;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clk) #1 o_wr = 1'b0;
        o_code = ~c;
        o_wdata = ~d;
        e = i_err;
    endtask
    task automatic rd_cmd(input logic [7:0] c, output pmbpc_word_t d);
        @(posedge i_clk) #1 o_code = c;
        o_rd = 1'b1;
        @(posedge i_clk) #1 o_rd = 1'b0;
        o_code = ~c;
        d = i_rdata;
    endtask
endmodule // pmbpc_host
`default_nettype wire

// ### tb/pmbpc_bank_tb.sv
/* Bench for the command bank: register table, refusals, on/off gating,
   margins, store and telemetry. Assumes the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "pmbpc_cfg.svh"
module pmbpc_bank_tb;
    import pmbpc_pkg::*;
    logic i_sys_clk = 0, i_sys_rst = 1, pin = 1, ce = 1, wr, rd, rvalid, err, en, store, e;
    logic [7:0] code;
    logic [10:0] iraw = 11'h120, craw = 11'h7F0;
    pmbpc_word_t wdata, rdata, tgt, d, keep, vraw = 16'h1000;
    pmbpc_margin_e msel;
    int err_total = 0, comparisons = 0, cyc = 0;
    // Reset words and telemetry from fixed samples
    logic [23:0] rt[15] = '{{`PMBPC_CMD_VIN_TURN_ON, 16'hE910}, {`PMBPC_CMD_VIN_TURN_OFF, 16'hE900},
        {`PMBPC_CMD_START_DELAY, 16'hF8A0}, {`PMBPC_CMD_START_RISE, 16'hF8A0}, {`PMBPC_CMD_SETPOINT, 16'hC000},
        {`PMBPC_CMD_MARGIN_HIGH, 16'hC800}, {`PMBPC_CMD_MARGIN_LOW, 16'hB800}, {`PMBPC_CMD_VOUT_MODE, 16'h0014},
        {`PMBPC_CMD_VOUT_CAL_OFS, 16'hFFF0}, {`PMBPC_CMD_VIN_CAL_GAIN, 16'h2000}, {`PMBPC_CMD_VIN_CAL_OFS, 16'hE804},
        {`PMBPC_CMD_IOUT_CAL_GAIN, 16'h2000}, {`PMBPC_CMD_READ_VIN, 16'hE924}, {`PMBPC_CMD_OUTPUT_VOLTAGE_READING, 16'h0FF0},
        {`PMBPC_CMD_READ_IOUT, 16'hE000}};
    // Writes with expected refusal; turn-off kept 2 V under turn-on
    logic [24:0] wt[14] = '{{`PMBPC_CMD_VIN_TURN_ON, 17'h1D2E0}, {`PMBPC_CMD_VIN_TURN_ON, 17'h1D2E3},
        {`PMBPC_CMD_VIN_TURN_ON, 17'h1E2E1}, {`PMBPC_CMD_VIN_TURN_OFF, 17'h1D2C0}, {`PMBPC_CMD_START_DELAY, 17'h1F0A0},
        {`PMBPC_CMD_START_DELAY, 17'h1F09F}, {`PMBPC_CMD_START_RISE, 17'h1F7D0}, {`PMBPC_CMD_START_RISE, 17'h1F7D3},
        {`PMBPC_CMD_SETPOINT, 17'h1A666}, {`PMBPC_CMD_SETPOINT, 17'h1A669}, {`PMBPC_CMD_SETPOINT, 17'h09FFF},
        {`PMBPC_CMD_MARGIN_LOW, 17'h01578}, {`PMBPC_CMD_MARGIN_HIGH, 17'h02468}, {`PMBPC_CMD_OUTPUT_VOLTAGE_READING, 17'h00001}};
    logic [7:0] mo[3] = '{8'h98, 8'hA8, 8'h88};
    logic [15:0] mt[3] = '{16'h0ABC, 16'h1234, 16'hD333};
    pmbpc_margin_e ms[3] = '{PMBPC_MARGIN_LOW, PMBPC_MARGIN_HIGH, PMBPC_MARGIN_OFF};
    pmbpc_host h (.i_clk(i_sys_clk), .i_rdata(rdata), .i_err(err), .o_code(code), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
    pmbpc_bank dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(ce), .i_cmd_code(code), .i_cmd_wr(wr),
        .i_cmd_wdata(wdata), .i_cmd_rd(rd), .o_cmd_rdata(rdata), .o_cmd_rvalid(rvalid), .o_cmd_err(err),
        .i_onoff_pin(pin), .i_vout_raw(vraw), .i_vin_raw(iraw), .i_iout_raw(craw),
        .i_output_voltage_cal_offset(16'hFFF0), .i_input_voltage_cal_offset(11'h004),
        .i_input_voltage_cal_gain(16'h2000), .i_output_current_cal_offset(11'h000),
        .i_output_current_cal_gain(16'h2000), .o_output_enable(en), .o_margin_sel(msel), .o_vout_target(tgt),
        .o_input_turn_on_threshold(), .o_input_turn_off_threshold(), .o_start_delay_time(), .o_start_rise_time(),
        .o_output_setpoint(), .o_margin_high_setpoint(), .o_margin_low_setpoint(), .o_nvm_store(store));
    task automatic chk(input pmbpc_word_t g, input pmbpc_word_t x);
        comparisons++;
        if (g !== x) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial forever #25 i_sys_clk = ~i_sys_clk;
    // Hang guard, far above the some 140 cycles needed
    always @(posedge i_sys_clk) if (++cyc > 3000) begin
        err_total++;
        conclude();
    end
    initial begin
        wait_cyc(16);
        i_sys_rst = 0;
        foreach (rt[i]) begin
            h.rd_cmd(rt[i][23:16], d);
            chk(d, rt[i][15:0]);
        end
        $display("reset and telemetry reads done");
        foreach (wt[i]) begin
            h.wr_cmd(wt[i][24:17], wt[i][16:1], e);
            chk(e, wt[i][0]);
            if (!wt[i][0]) keep = wt[i][16:1];
            if (!wt[i][24]) h.rd_cmd(wt[i][24:17], d);
            if (!wt[i][24]) chk(d, keep);
        end
        $display("write range checks done");
        chk(en, 1);
        h.wr_cmd(`PMBPC_CMD_MAIN_CONTROL, 16'h0008, e);
        wait_cyc(3);
        chk(en, 0);
        h.wr_cmd(`PMBPC_CMD_ONOFF_CONFIG, 16'h0000, e);
        wait_cyc(3);
        chk(en, 1);
        h.rd_cmd(`PMBPC_CMD_ONOFF_CONFIG, d);
        chk(d[4:0], 5'h17);
        h.wr_cmd(`PMBPC_CMD_ONOFF_CONFIG, 16'h00FF, e);
        h.rd_cmd(`PMBPC_CMD_ONOFF_CONFIG, d);
        chk(d[4:0], 5'h1F);
        h.wr_cmd(`PMBPC_CMD_MAIN_CONTROL, 16'h00FF, e);
        h.rd_cmd(`PMBPC_CMD_MAIN_CONTROL, d);
        chk(d[7:0], 8'hB8);
        pin = 0;
        wait_cyc(5);
        chk(en, 0);
        pin = 1;
        $display("on/off gating done");
        for (int i = 0; i < 3; i++) begin
            h.wr_cmd(`PMBPC_CMD_MAIN_CONTROL, {8'h00, mo[i]}, e);
            wait_cyc(2);
            chk(msel, ms[i]);
            chk(tgt, mt[i]);
        end
        ce = 0;
        h.wr_cmd(`PMBPC_CMD_STORE_ALL, 16'h0000, e);
        chk(store, 0);
        ce = 1;
        h.wr_cmd(`PMBPC_CMD_STORE_ALL, 16'h0000, e);
        chk(store, 1);
        $display("margin and store done");
        conclude();
    end
endmodule // pmbpc_bank_tb
`default_nettype wire
